//--- cfb_pkg.sv
// shared constants and types of the control-flow and compare unit
package cfb_pkg;
    // bit positions inside status_flags
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_H = 5;
    localparam int FLAG_I = 7;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // operation lengths in clock cycles
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_CALL = 3'h3;
    localparam logic [2:0] CYC_EXIT = 3'h4;
    localparam logic [2:0] CYC_BR_TAKEN = 3'h2;
    localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
    localparam logic [2:0] CYC_SKIP_TWO = 3'h3;

    // program counter steps in words
    localparam int STEP_SEQ = 1;
    localparam int STEP_SKIP_ONE = 2;
    localparam int STEP_SKIP_TWO = 3;
    localparam int BRANCH_BIAS = 1;
    localparam int OFFSET_W = 7;

    // operations handed over by the instruction decoder
    typedef enum logic [4:0] {
        OP_PTR_CALL, OP_SUB_EXIT, OP_IRQ_EXIT, OP_CMP_SKIP_EQ, OP_CMP_REG,
        OP_CMP_CARRY, OP_CMP_CONST, OP_SKIP_RBIT_LO, OP_SKIP_RBIT_HI,
        OP_SKIP_IOBIT_LO, OP_SKIP_IOBIT_HI, OP_BR_FLAG_HI, OP_BR_FLAG_LO,
        OP_BR_EQ, OP_BR_NE, OP_BR_CARRY_HI, OP_BR_CARRY_LO, OP_BR_UNS_GE
    } cfb_op_e;

    // sequencer states
    typedef enum logic {ST_IDLE, ST_RUN} cfb_state_e;
endpackage

//--- cfb_unit.sv
// control transfer, compare, skip and relative branch unit of the core

// Notes on behaviour
// RQ1 - a pointer call pushes the return address and loads the pc from the pointer pair.
// RQ2 - both exits reload the pc from the stack, and the interrupt exit also sets the I flag.
// RQ3 - compare-skip-on-equal skips the next instruction when both registers match, flags kept.
// RQ4 - register compare forms dst minus src (minus carry for the carry form) and sets Z N V C H.
// RQ5 - constant compare forms dst minus the constant and sets flags like a register compare.
// RQ6 - register bit skips skip when the chosen bit is low or high, per variant.
// RQ7 - i/o bit skips skip when the chosen i/o bit is low or high, per variant, flags kept.
// RQ8 - general flag branches jump to pc plus offset plus one when the chosen flag matches.
// RQ9 - equal and unequal branches jump on Z set and Z clear respectively.
// RQ10 - carry branches jump on C set and C clear respectively.
// RQ11 - the unsigned same-or-higher branch behaves as the carry-clear branch.
// RQ12 - branches take one or two cycles and skips one, two or three by outcome.
// RQ13 - a skip steps over one instruction: two words for a short one, three for a long one.
module cfb_unit #(
    parameter int PC_W = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // operation from the decoder
    input wire logic op_valid,
    input wire cfb_pkg::cfb_op_e op_code,
    input wire logic [PC_W-1:0] pc_now,
    input wire logic next_two_word,
    // operands
    input wire logic [PC_W-1:0] pointer_z,
    input wire logic [PC_W-1:0] stack_top,
    input wire logic [7:0] reg_dst,
    input wire logic [7:0] reg_src,
    input wire logic [7:0] const_k,
    input wire logic [7:0] io_value,
    input wire logic [2:0] bit_sel,
    input wire logic [2:0] flag_sel,
    input wire logic [cfb_pkg::OFFSET_W-1:0] rel_offset,
    input wire logic [7:0] status_flags,
    // sequencing
    output logic busy,
    output logic done,
    // program counter and stack
    output logic pc_load,
    output logic [PC_W-1:0] pc_next,
    output logic push_req,
    output logic [PC_W-1:0] push_addr,
    output logic pop_req,
    // status register update
    output logic flags_we,
    output logic [7:0] status_next,
    output logic irq_enable_set
);
    // refuse pc widths the offset and step arithmetic cannot serve
    if (PC_W < 8 || PC_W > 22) begin : g_width_check
        $error("cfb_unit: PC_W must lie between 8 and 22");
    end

    typedef struct packed {
        cfb_pkg::cfb_state_e state;
        logic [2:0] remain;
        logic from_stack;
        logic irq_exit;
        logic [PC_W-1:0] pend_pc;
        logic busy;
        logic done;
        logic pc_load;
        logic [PC_W-1:0] pc_next;
        logic push_req;
        logic [PC_W-1:0] push_addr;
        logic pop_req;
        logic flags_we;
        logic [7:0] status_next;
        logic irq_enable_set;
    } cfb_unit_s;

    cfb_unit_s st;
    cfb_unit_s next_st;

    logic accept;
    logic carry_in;
    logic [7:0] subtrahend;
    logic [8:0] diff;
    logic [7:0] res;
    logic [7:0] cmp_flags;
    logic [PC_W-1:0] seq_pc;
    logic [PC_W-1:0] skip_pc;
    logic [PC_W-1:0] br_target;
    logic is_branch;
    logic take;
    logic skip;

    // a new operation is only taken while the sequencer is idle
    assign accept = op_valid && st.state == cfb_pkg::ST_IDLE;

    // shared subtractor; the result itself is never stored
    assign carry_in = op_code == cfb_pkg::OP_CMP_CARRY && status_flags[cfb_pkg::FLAG_C]; // RQ4
    assign subtrahend = op_code == cfb_pkg::OP_CMP_CONST ? const_k : reg_src; // RQ5
    assign diff = {1'b0, reg_dst} - {1'b0, subtrahend} - {8'h00, carry_in}; // RQ4
    assign res = diff[7:0];

    // flag update of all three compare forms
    always_comb begin
        cmp_flags = status_flags;
        cmp_flags[cfb_pkg::FLAG_N] = res[7]; // RQ4
        cmp_flags[cfb_pkg::FLAG_H] = (~reg_dst[3] & subtrahend[3]) | (subtrahend[3] & res[3])
            | (res[3] & ~reg_dst[3]); // RQ4
        cmp_flags[cfb_pkg::FLAG_V] = (reg_dst[7] & ~subtrahend[7] & ~res[7])
            | (~reg_dst[7] & subtrahend[7] & res[7]); // RQ4
        cmp_flags[cfb_pkg::FLAG_C] = (~reg_dst[7] & subtrahend[7]) | (subtrahend[7] & res[7])
            | (res[7] & ~reg_dst[7]); // RQ4
        // the carry form keeps Z only while every byte of a chain compares zero
        if (op_code == cfb_pkg::OP_CMP_CARRY) begin
            cmp_flags[cfb_pkg::FLAG_Z] = res == 8'h00 && status_flags[cfb_pkg::FLAG_Z];
        end else begin
            cmp_flags[cfb_pkg::FLAG_Z] = res == 8'h00; // RQ5
        end
    end

    // candidate program counter values
    assign seq_pc = pc_now + PC_W'(cfb_pkg::STEP_SEQ);
    assign skip_pc = pc_now + (next_two_word ? PC_W'(cfb_pkg::STEP_SKIP_TWO)
        : PC_W'(cfb_pkg::STEP_SKIP_ONE)); // RQ13
    assign br_target = pc_now + {{(PC_W - cfb_pkg::OFFSET_W){rel_offset[cfb_pkg::OFFSET_W-1]}},
        rel_offset} + PC_W'(cfb_pkg::BRANCH_BIAS); // RQ8

    // branch and skip conditions
    always_comb begin
        is_branch = 1'b1;
        take = 1'b0;
        skip = 1'b0;
        case (op_code)
            cfb_pkg::OP_BR_FLAG_HI: take = status_flags[flag_sel]; // RQ8
            cfb_pkg::OP_BR_FLAG_LO: take = !status_flags[flag_sel]; // RQ8
            cfb_pkg::OP_BR_EQ: take = status_flags[cfb_pkg::FLAG_Z]; // RQ9
            cfb_pkg::OP_BR_NE: take = !status_flags[cfb_pkg::FLAG_Z]; // RQ9
            cfb_pkg::OP_BR_CARRY_HI: take = status_flags[cfb_pkg::FLAG_C]; // RQ10
            cfb_pkg::OP_BR_CARRY_LO,
            cfb_pkg::OP_BR_UNS_GE: take = !status_flags[cfb_pkg::FLAG_C]; // RQ10 RQ11
            default: begin
                is_branch = 1'b0;
                case (op_code)
                    cfb_pkg::OP_CMP_SKIP_EQ: skip = reg_dst == reg_src; // RQ3
                    cfb_pkg::OP_SKIP_RBIT_LO: skip = !reg_src[bit_sel]; // RQ6
                    cfb_pkg::OP_SKIP_RBIT_HI: skip = reg_src[bit_sel]; // RQ6
                    cfb_pkg::OP_SKIP_IOBIT_LO: skip = !io_value[bit_sel]; // RQ7
                    cfb_pkg::OP_SKIP_IOBIT_HI: skip = io_value[bit_sel]; // RQ7
                    default: skip = 1'b0;
                endcase
            end
        endcase
    end

    // sequencer: one-cycle work finishes at once, longer work counts down
    always_comb begin
        logic [2:0] cyc;
        logic [PC_W-1:0] tgt;
        cyc = cfb_pkg::CYC_ONE;
        tgt = seq_pc;
        next_st = st;
        next_st.done = 1'b0;
        next_st.pc_load = 1'b0;
        next_st.push_req = 1'b0;
        next_st.pop_req = 1'b0;
        next_st.flags_we = 1'b0;
        next_st.irq_enable_set = 1'b0;
        case (st.state)
            cfb_pkg::ST_IDLE: begin
                if (accept) begin
                    next_st.from_stack = 1'b0;
                    next_st.irq_exit = 1'b0;
                    case (op_code)
                        cfb_pkg::OP_PTR_CALL: begin
                            cyc = cfb_pkg::CYC_CALL;
                            tgt = pointer_z; // RQ1
                            next_st.push_req = 1'b1; // RQ1
                            next_st.push_addr = seq_pc;
                        end
                        cfb_pkg::OP_SUB_EXIT,
                        cfb_pkg::OP_IRQ_EXIT: begin
                            cyc = cfb_pkg::CYC_EXIT;
                            next_st.pop_req = 1'b1; // RQ2
                            next_st.from_stack = 1'b1;
                            next_st.irq_exit = op_code == cfb_pkg::OP_IRQ_EXIT; // RQ2
                        end
                        cfb_pkg::OP_CMP_REG,
                        cfb_pkg::OP_CMP_CARRY,
                        cfb_pkg::OP_CMP_CONST: begin
                            next_st.flags_we = 1'b1; // RQ4 RQ5
                            next_st.status_next = cmp_flags;
                        end
                        default: begin
                            if (is_branch && take) begin
                                cyc = cfb_pkg::CYC_BR_TAKEN; // RQ12
                                tgt = br_target; // RQ8 RQ9 RQ10
                            end else if (skip) begin
                                cyc = next_two_word ? cfb_pkg::CYC_SKIP_TWO
                                    : cfb_pkg::CYC_SKIP_ONE; // RQ12
                                tgt = skip_pc; // RQ13
                            end
                        end
                    endcase
                    if (cyc == cfb_pkg::CYC_ONE) begin
                        next_st.done = 1'b1;
                        next_st.pc_load = 1'b1;
                        next_st.pc_next = tgt;
                    end else begin
                        next_st.state = cfb_pkg::ST_RUN;
                        next_st.busy = 1'b1;
                        next_st.remain = cyc - cfb_pkg::CYC_ONE;
                        next_st.pend_pc = tgt;
                    end
                end
            end
            cfb_pkg::ST_RUN: begin
                next_st.remain = st.remain - cfb_pkg::CYC_ONE;
                if (st.remain == cfb_pkg::CYC_ONE) begin
                    next_st.state = cfb_pkg::ST_IDLE;
                    next_st.busy = 1'b0;
                    next_st.done = 1'b1;
                    next_st.pc_load = 1'b1;
                    // the stack answers late, so its word is taken on the last edge
                    next_st.pc_next = st.from_stack ? stack_top : st.pend_pc; // RQ2
                    next_st.irq_enable_set = st.irq_exit; // RQ2
                end
            end
            default: next_st.state = cfb_pkg::ST_IDLE;
        endcase
    end

    // state register, synchronous reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '0;
            st.state <= cfb_pkg::ST_IDLE;
            st.status_next <= cfb_pkg::FLAGS_RESET;
        end else begin
            st <= next_st;
        end
    end

    // every output straight from the state register
    assign busy = st.busy;
    assign done = st.done;
    assign pc_load = st.pc_load;
    assign pc_next = st.pc_next;
    assign push_req = st.push_req;
    assign push_addr = st.push_addr;
    assign pop_req = st.pop_req;
    assign flags_we = st.flags_we;
    assign status_next = st.status_next;
    assign irq_enable_set = st.irq_enable_set;

    // checks
    chk_call_push: assert property (@(posedge clock) disable iff (!rst_n) // RQ1
        (accept && op_code == cfb_pkg::OP_PTR_CALL) |=> push_req
        && push_addr == $past(seq_pc) ##2 (done && pc_next == $past(pointer_z, 3)))
        else $error("pointer call push or target wrong");
    chk_exit_pop: assert property (@(posedge clock) disable iff (!rst_n) // RQ2
        (accept && (op_code == cfb_pkg::OP_SUB_EXIT || op_code == cfb_pkg::OP_IRQ_EXIT))
        |=> pop_req ##3 (done && pc_load && pc_next == $past(stack_top)))
        else $error("exit did not reload pc from stack");
    chk_irq_exit_flag: assert property (@(posedge clock) disable iff (!rst_n) // RQ2
        (accept && op_code == cfb_pkg::OP_IRQ_EXIT) |=> !irq_enable_set [*3] ##1 irq_enable_set)
        else $error("interrupt exit did not set enable");
    chk_skip_equal: assert property (@(posedge clock) disable iff (!rst_n) // RQ3
        (accept && op_code == cfb_pkg::OP_CMP_SKIP_EQ && reg_dst == reg_src && !next_two_word)
        |=> !done ##1 (done && !flags_we && pc_next == $past(pc_now, 2) + PC_W'(2)))
        else $error("equal skip wrong");
    chk_cmp_flags: assert property (@(posedge clock) disable iff (!rst_n) // RQ4
        (accept && op_code == cfb_pkg::OP_CMP_REG) |=> (flags_we
        && status_next[cfb_pkg::FLAG_Z] == ($past(reg_dst) == $past(reg_src))
        && status_next[cfb_pkg::FLAG_C] == ($past(reg_dst) < $past(reg_src))))
        else $error("register compare flags wrong");
    chk_const_flags: assert property (@(posedge clock) disable iff (!rst_n) // RQ5
        (accept && op_code == cfb_pkg::OP_CMP_CONST) |=> (flags_we
        && status_next[cfb_pkg::FLAG_C] == ($past(reg_dst) < $past(const_k))))
        else $error("constant compare flags wrong");
    chk_rbit_noskip: assert property (@(posedge clock) disable iff (!rst_n) // RQ6
        (accept && op_code == cfb_pkg::OP_SKIP_RBIT_HI && !reg_src[bit_sel])
        |=> (done && pc_next == $past(pc_now) + PC_W'(1)))
        else $error("register bit skip taken wrongly");
    chk_iobit_skip: assert property (@(posedge clock) disable iff (!rst_n) // RQ7 RQ13
        (accept && op_code == cfb_pkg::OP_SKIP_IOBIT_LO && !io_value[bit_sel] && next_two_word)
        |=> !done [*2] ##1 (done && !flags_we && pc_next == $past(pc_now, 3) + PC_W'(3)))
        else $error("i/o bit skip over long instruction wrong");
    chk_branch_taken: assert property (@(posedge clock) disable iff (!rst_n) // RQ8 RQ9 RQ10
        (accept && is_branch && take) |=> !done ##1 (done && pc_next == $past(br_target, 2)))
        else $error("taken branch target or timing wrong");
    chk_branch_seq: assert property (@(posedge clock) disable iff (!rst_n) // RQ12
        (accept && is_branch && !take) |=> (done && pc_next == $past(pc_now) + PC_W'(1)))
        else $error("untaken branch wrong");
    chk_uns_ge_carry: assert property (@(posedge clock) disable iff (!rst_n) // RQ11
        (accept && op_code == cfb_pkg::OP_BR_UNS_GE)
        |=> (done != $past(!status_flags[cfb_pkg::FLAG_C])))
        else $error("same-or-higher branch not following carry clear");
endmodule

//--- cfb_far_end.sv
// model of stack and status register beside the unit
module cfb_far_end #(
    parameter int PC_W = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // requests from the unit
    input wire logic push_req,
    input wire logic [PC_W-1:0] push_addr,
    input wire logic pop_req,
    input wire logic flags_we,
    input wire logic [7:0] status_next,
    input wire logic irq_enable_set,
    // bench preset of the status bits
    input wire logic preset_we,
    input wire logic [7:0] preset_val,
    // answers to the unit
    output logic [PC_W-1:0] stack_top,
    output logic [7:0] status_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [PC_W-1:0] mem [16];
    logic [3:0] sp;
    logic [1:0] win;
    // top is valid two cycles after a pop, inverted otherwise so stale use shows
    assign stack_top = (win != 2'h0) ? mem[sp - 4'h1] : ~mem[sp - 4'h1];
    // stack pointer, pop window and status register
    always @(posedge clock) begin
        if (!rst_n) begin
            sp <= 4'h0;
            win <= 2'h0;
            status_flags <= 8'h00;
        end else begin
            if (push_req) begin
                mem[sp] <= push_addr;
                sp <= sp + 4'h1;
            end
            if (pop_req) begin
                win <= 2'h2;
            end else if (win != 2'h0) begin
                win <= win - 2'h1;
                if (win == 2'h1) sp <= sp - 4'h1;
            end
            if (flags_we) status_flags <= status_next;
            if (irq_enable_set) status_flags[cfb_pkg::FLAG_I] <= 1'b1;
            if (preset_we) status_flags <= preset_val;
        end
    end
endmodule

//--- cfb_unit_tb.sv
// self-checking bench of the control-flow and compare unit
module cfb_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 16;
    logic clock, rst_n, op_valid, next_two_word, preset_we;
    cfb_pkg::cfb_op_e op_code, o;
    logic [W-1:0] pc_now, pointer_z, stack_top, pc_next, push_addr;
    logic [7:0] reg_dst, reg_src, const_k, io_value, status_flags, status_next, preset_val;
    logic [2:0] bit_sel, flag_sel;
    logic [cfb_pkg::OFFSET_W-1:0] rel_offset;
    logic busy, done, pc_load, push_req, pop_req, flags_we, irq_enable_set;
    int fail_count, total_checks;
    logic [W-1:0] stk [$];
    cfb_unit #(.PC_W(W)) i_dut (.clock(clock), .rst_n(rst_n), .op_valid(op_valid),
        .op_code(op_code), .pc_now(pc_now), .next_two_word(next_two_word),
        .pointer_z(pointer_z), .stack_top(stack_top), .reg_dst(reg_dst), .reg_src(reg_src),
        .const_k(const_k), .io_value(io_value), .bit_sel(bit_sel), .flag_sel(flag_sel),
        .rel_offset(rel_offset), .status_flags(status_flags), .busy(busy), .done(done),
        .pc_load(pc_load), .pc_next(pc_next), .push_req(push_req), .push_addr(push_addr),
        .pop_req(pop_req), .flags_we(flags_we), .status_next(status_next),
        .irq_enable_set(irq_enable_set));
    cfb_far_end #(.PC_W(W)) i_far (.clock(clock), .rst_n(rst_n), .push_req(push_req),
        .push_addr(push_addr), .pop_req(pop_req), .flags_we(flags_we),
        .status_next(status_next), .irq_enable_set(irq_enable_set), .preset_we(preset_we),
        .preset_val(preset_val), .stack_top(stack_top), .status_flags(status_flags));
    // 40 MHz core clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic miss(string m);
        fail_count++;
        $display("MISMATCH at %0t: %s", $time, m);
    endtask
    task automatic chk_pc(logic [W-1:0] g, logic [W-1:0] e);
        total_checks++;
        if (g !== e) miss($sformatf("op %s pc %h want %h", o.name(), g, e));
    endtask
    task automatic chk_byte(logic [7:0] g, logic [7:0] e);
        total_checks++;
        if (g !== e) miss($sformatf("op %s flags %h want %h", o.name(), g, e));
    endtask
    task automatic chk_bit(logic g, logic e);
        total_checks++;
        if (g !== e) miss($sformatf("op %s strobe %b want %b", o.name(), g, e));
    endtask
    task automatic chk_cnt(int g, int e);
        total_checks++;
        if (g != e) miss($sformatf("op %s cycles %0d want %0d", o.name(), g, e));
    endtask
    // subtract flags; the carry form keeps Z only if it was already set
    function automatic logic [7:0] sub_flags(logic [7:0] d, logic [7:0] s, logic cf,
                                            logic [7:0] f);
        logic [7:0] r;
        r = d - s - {7'h00, cf & f[cfb_pkg::FLAG_C]};
        f[cfb_pkg::FLAG_H] = (~d[3] & s[3]) | (s[3] & r[3]) | (r[3] & ~d[3]);
        f[cfb_pkg::FLAG_V] = (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]);
        f[cfb_pkg::FLAG_C] = (~d[7] & s[7]) | (s[7] & r[7]) | (r[7] & ~d[7]);
        f[cfb_pkg::FLAG_Z] = (r == 8'h00) & (~cf | f[cfb_pkg::FLAG_Z]);
        f[cfb_pkg::FLAG_N] = r[7];
        return f;
    endfunction
    // one operation: drive, wait for done under a bound, compare
    task automatic run(cfb_pkg::cfb_op_e op, logic [W-1:0] pc, logic [7:0] d, logic [7:0] s,
                       logic [7:0] sf, logic [6:0] off, logic [2:0] b, logic two);
        logic [W-1:0] pz, epc, pa;
        logic [7:0] k, io, ef;
        logic [2:0] fs;
        logic hit, fwe, psh, pop, irq, cmp;
        int n, ecyc, kind, nb;
        pz = W'($urandom());
        k = 8'($urandom());
        io = 8'($urandom());
        fs = 3'($urandom());
        o = op;
        epc = pc + 1'b1;
        ecyc = 1;
        ef = sf;
        kind = 0;
        hit = 1'b0;
        cmp = op inside {cfb_pkg::OP_CMP_REG, cfb_pkg::OP_CMP_CARRY, cfb_pkg::OP_CMP_CONST};
        case (op)
            cfb_pkg::OP_PTR_CALL: begin epc = pz; ecyc = 3; end
            cfb_pkg::OP_SUB_EXIT, cfb_pkg::OP_IRQ_EXIT: begin epc = stk.pop_back(); ecyc = 4; end
            cfb_pkg::OP_CMP_REG: ef = sub_flags(d, s, 1'b0, sf);
            cfb_pkg::OP_CMP_CARRY: ef = sub_flags(d, s, 1'b1, sf);
            cfb_pkg::OP_CMP_CONST: ef = sub_flags(d, k, 1'b0, sf);
            cfb_pkg::OP_CMP_SKIP_EQ: begin kind = 1; hit = (d == s); end
            cfb_pkg::OP_SKIP_RBIT_LO: begin kind = 1; hit = !s[b]; end
            cfb_pkg::OP_SKIP_RBIT_HI: begin kind = 1; hit = s[b]; end
            cfb_pkg::OP_SKIP_IOBIT_LO: begin kind = 1; hit = !io[b]; end
            cfb_pkg::OP_SKIP_IOBIT_HI: begin kind = 1; hit = io[b]; end
            cfb_pkg::OP_BR_FLAG_HI: begin kind = 2; hit = sf[fs]; end
            cfb_pkg::OP_BR_FLAG_LO: begin kind = 2; hit = !sf[fs]; end
            cfb_pkg::OP_BR_EQ: begin kind = 2; hit = sf[cfb_pkg::FLAG_Z]; end
            cfb_pkg::OP_BR_NE: begin kind = 2; hit = !sf[cfb_pkg::FLAG_Z]; end
            cfb_pkg::OP_BR_CARRY_HI: begin kind = 2; hit = sf[cfb_pkg::FLAG_C]; end
            default: begin kind = 2; hit = !sf[cfb_pkg::FLAG_C]; end
        endcase
        if (kind == 1 && hit) begin
            epc = pc + (two ? 2'h3 : 2'h2);
            ecyc = two ? 3 : 2;
        end
        if (kind == 2 && hit) begin
            epc = pc + {{(W-7){off[6]}}, off} + 1'b1;
            ecyc = 2;
        end
        if (op == cfb_pkg::OP_PTR_CALL) stk.push_back(pc + 1'b1);
        // status preset lands one edge ahead, so the unit sees sf when it takes the op
        @(posedge clock);
        preset_we <= 1'b1;
        preset_val <= sf;
        @(posedge clock);
        preset_we <= 1'b0;
        op_valid <= 1'b1;
        op_code <= op;
        pc_now <= pc;
        reg_dst <= d;
        reg_src <= s;
        rel_offset <= off;
        bit_sel <= b;
        next_two_word <= two;
        pointer_z <= pz;
        const_k <= k;
        io_value <= io;
        flag_sel <= fs;
        {n, nb, fwe, psh, pop, irq, pa} = '0;
        do begin
            @(posedge clock);
            if (n == 0) op_valid <= 1'b0;
            n++;
            #1;
            if (busy === 1'b1) nb++;
            {fwe, psh, pop, irq} |= {flags_we, push_req, pop_req, irq_enable_set};
            if (push_req) pa = push_addr;
        end while (done !== 1'b1 && n < 8);
        if (done !== 1'b1) begin
            miss("no completion");
            end_of_test();
        end
        chk_cnt(n, ecyc);
        chk_cnt(nb, ecyc - 1);
        chk_bit(pc_load, 1'b1);
        chk_pc(pc_next, epc);
        chk_bit(fwe, cmp);
        if (cmp) chk_byte(status_next, ef);
        chk_bit(psh, op == cfb_pkg::OP_PTR_CALL);
        if (psh) chk_pc(pa, pc + 1'b1);
        chk_bit(pop, op inside {cfb_pkg::OP_SUB_EXIT, cfb_pkg::OP_IRQ_EXIT});
        chk_bit(irq, op == cfb_pkg::OP_IRQ_EXIT);
    endtask
    // reset, corner cases, then random operations
    initial begin
        {rst_n, op_valid, next_two_word, preset_we} = 4'h0;
        {pc_now, pointer_z, reg_dst, reg_src, const_k, io_value, preset_val} = '0;
        {bit_sel, flag_sel, rel_offset} = '0;
        op_code = cfb_pkg::OP_CMP_REG;
        fail_count = 0;
        total_checks = 0;
        void'($urandom(6000));
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        run(cfb_pkg::OP_PTR_CALL, 16'hFFFF, 8'h00, 8'h00, 8'h00, 7'h00, 3'h0, 1'b0);
        run(cfb_pkg::OP_IRQ_EXIT, 16'h1234, 8'h00, 8'h00, 8'h00, 7'h00, 3'h0, 1'b0);
        run(cfb_pkg::OP_BR_UNS_GE, 16'h0100, 8'h00, 8'h00, 8'h00, 7'h40, 3'h0, 1'b0);
        run(cfb_pkg::OP_BR_UNS_GE, 16'h0100, 8'h00, 8'h00, 8'h01, 7'h3F, 3'h0, 1'b0);
        run(cfb_pkg::OP_CMP_CARRY, 16'h0200, 8'h10, 8'h0F, 8'h03, 7'h00, 3'h0, 1'b0);
        run(cfb_pkg::OP_CMP_SKIP_EQ, 16'h0300, 8'h5A, 8'h5A, 8'h00, 7'h00, 3'h0, 1'b1);
        run(cfb_pkg::OP_SKIP_RBIT_HI, 16'h0400, 8'h00, 8'h80, 8'hFF, 7'h00, 3'h7, 1'b0);
        $display("test corners done");
        repeat (400) begin
            o = cfb_pkg::cfb_op_e'($urandom_range(17));
            if (o inside {cfb_pkg::OP_SUB_EXIT, cfb_pkg::OP_IRQ_EXIT} && stk.size() == 0)
                o = cfb_pkg::OP_PTR_CALL;
            if (o == cfb_pkg::OP_PTR_CALL && stk.size() > 14) o = cfb_pkg::OP_SUB_EXIT;
            run(o, W'($urandom()), 8'($urandom()), 8'($urandom()), 8'($urandom()),
                7'($urandom()), 3'($urandom()), 1'($urandom()));
        end
        $display("test random done");
        end_of_test();
    end
endmodule
